// ==== include/cfg_port_if.sv ====
// Interface joining the application end and the device end of the access port
`default_nettype none
interface cfg_port_if;
    logic                             rd_en;
    logic                             wr_en;
    logic [cfg_port_pkg::ADDR_W-1:0]  addr;
    logic [cfg_port_pkg::DATA_W-1:0]  wdata;
    logic [cfg_port_pkg::DATA_W-1:0]  rdata;
    logic                             ack;

    modport dev (input rd_en, input wr_en, input addr, input wdata, output rdata, output ack);
    modport app (output rd_en, output wr_en, output addr, output wdata, input rdata, input ack);
endinterface
`default_nettype wire

// ==== include/cfg_port_pkg.sv ====
// Shared constants and types for the local configuration space access port
`default_nettype none
package cfg_port_pkg;
    localparam int ADDR_W          = 15;
    localparam int DATA_W          = 32;
    localparam int IDX_W           = 4;
    localparam int NUM_REGS        = 16;
    localparam int IDX_LSB         = 2;
    localparam int MAX_FREQ_MHZ    = 250;
    localparam int CLK_FREQ_MHZ    = 20;
    localparam int ACK_LAT_MIN     = 2;

    localparam logic [ADDR_W-1:0]  UNMAPPED_MASK = 15'h7fc0;
    localparam logic [DATA_W-1:0]  DATA_ZERO     = 32'h0000_0000;

    // Reset contents of the modelled registers; index 0 value is arbitrary
    localparam logic [NUM_REGS-1:0][DATA_W-1:0] REG_RST = {
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0010_0000, 32'h5a5a_a5a5
    };

    // Writable bits per register; zero bits are read-only
    localparam logic [NUM_REGS-1:0][DATA_W-1:0] REG_WMASK = {
        32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_00ff, 32'hffff_fff0, 32'hffff_fff0, 32'hffff_fff0,
        32'h0000_ff00, 32'h0000_00ff, 32'h0000_0547, 32'h0000_0000
    };

    typedef enum logic [0:0] {
        DEV_IDLE = 1'b0,
        DEV_WAIT = 1'b1
    } dev_fsm_t;

    typedef enum logic [0:0] {
        APP_IDLE = 1'b0,
        APP_WAIT = 1'b1
    } app_fsm_t;
endpackage
`default_nettype wire

// ==== sim/cfg_port_checker.sv ====
// Concurrent checks on the local port between the two ends
`default_nettype none
module cfg_port_checker (
    // Clock and reset
    input wire logic                             mclk,
    input wire logic                             rst_n,
    // Port signals
    input wire logic                             rd_en,
    input wire logic                             wr_en,
    input wire logic [cfg_port_pkg::ADDR_W-1:0]  addr,
    input wire logic [cfg_port_pkg::DATA_W-1:0]  rdata,
    input wire logic                             ack
);
    import cfg_port_pkg::*;
    logic stb;
    logic pend_r;
    logic pend_nxt;
    assign stb = rd_en | wr_en;
    // Tracks one operation taken and not yet acknowledged
    always_comb begin
        pend_nxt = stb ? 1'b1 : (ack ? 1'b0 : pend_r);
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) pend_r <= 1'b0;
        else pend_r <= pend_nxt;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_one_op; !(rd_en && wr_en); endproperty
    a_one_op: assert property (p_one_op) else $error("both strobes high");
    property p_no_early_ack; stb |=> !ack; endproperty
    a_no_early_ack: assert property (p_no_early_ack) else $error("ack too early");
    property p_ack_bound; stb |-> ##[2:40] ack; endproperty
    a_ack_bound: assert property (p_ack_bound) else $error("ack missing");
    property p_ack_pulse; ack |=> !ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_owned; ack |-> pend_r; endproperty
    a_ack_owned: assert property (p_ack_owned) else $error("ack without operation");
    property p_spacing; stb |=> (!stb) [*3]; endproperty
    a_spacing: assert property (p_spacing) else $error("second operation outstanding");
    property p_align; stb |-> addr[1:0] == 2'h0; endproperty
    a_align: assert property (p_align) else $error("address not word aligned");
    property p_rdata_hold; !ack |-> $stable(rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule
`default_nettype wire

// ==== sim/local_config_space_access_port_tb_top.sv ====
// Testbench joining both ends of the local configuration port
`default_nettype none
module local_config_space_access_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import cfg_port_pkg::*;
    logic              mclk = 1'b0;
    logic              rst_n = 1'b0;
    logic              cmd_rd = 1'b0;
    logic              cmd_wr = 1'b0;
    logic              link_req = 1'b0;
    logic              link_we = 1'b0;
    logic [ADDR_W-1:0] cmd_addr = '0;
    logic [ADDR_W-1:0] link_addr = '0;
    logic [DATA_W-1:0] cmd_wdata = '0;
    logic [DATA_W-1:0] link_wdata = '0;
    logic              cmd_busy, cmd_done, link_ack;
    logic [DATA_W-1:0] cmd_rdata, link_rdata;
    logic [DATA_W-1:0] mem [NUM_REGS];
    logic [DATA_W:0]   pq[$], lq[$];
    int                failures = 0, comparisons = 0, cyc = 0, seed = 95, i, k;
    always #25 mclk = ~mclk;
    cfg_port_if pif ();
    cfg_port_dev cfg_port_dev_inst (.mclk(mclk), .rst_n(rst_n), .port(pif.dev), .link_req(link_req),
        .link_we(link_we), .link_addr(link_addr), .link_wdata(link_wdata), .link_rdata(link_rdata),
        .link_ack(link_ack));
    cfg_port_app cfg_port_app_inst (.mclk(mclk), .rst_n(rst_n), .cmd_rd(cmd_rd), .cmd_wr(cmd_wr),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_busy(cmd_busy), .cmd_done(cmd_done),
        .cmd_rdata(cmd_rdata), .port(pif.app));
    cfg_port_checker cfg_port_checker_inst (.mclk(mclk), .rst_n(rst_n), .rd_en(pif.rd_en),
        .wr_en(pif.wr_en), .addr(pif.addr), .rdata(pif.rdata), .ack(pif.ack));
    ////////////////////////////////////////////////////////////////
    function automatic logic [DATA_W-1:0] rd_val(logic [ADDR_W-1:0] a);
        return (a & UNMAPPED_MASK) != '0 ? DATA_ZERO : mem[a[IDX_LSB+:IDX_W]];
    endfunction
    // Only writable bits of a mapped register change
    task automatic wr_model(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        logic [IDX_W-1:0] x;
        x = a[IDX_LSB+:IDX_W];
        if ((a & UNMAPPED_MASK) == '0) mem[x] = (mem[x] & ~REG_WMASK[x]) | (d & REG_WMASK[x]);
    endtask
    task automatic chk(logic [DATA_W:0] n, logic [DATA_W-1:0] got);
        if (n[DATA_W]) begin
            comparisons++;
            if (got !== n[DATA_W-1:0]) begin
                failures++;
                $display("ERROR at %0t: expected %h got %h", $time, n[DATA_W-1:0], got);
            end
        end
    endtask
    // One link access per cycle, noted and modelled at once
    task automatic link_op;
        k = $random(seed);
        link_req = 1'b1;
        link_we = k[0];
        link_addr = k[15:1] & 15'h007f;
        link_wdata = $random(seed);
        lq.push_back({~k[0], rd_val(link_addr)});
        if (k[0]) wr_model(link_addr, link_wdata);
        @(posedge mclk);
        #1;
    endtask
    task automatic port_op(logic r, logic w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d, int nl);
        int n;
        cmd_rd = r;
        cmd_wr = w;
        cmd_addr = a;
        cmd_wdata = d;
        @(posedge mclk);
        #1;
        chk({1'b1, 32'h0000_0001}, {31'h0000_0000, cmd_busy});
        cmd_rd = 1'b0;
        cmd_wr = 1'b0;
        repeat (nl) link_op();
        link_req = 1'b0;
        pq.push_back({~w, rd_val(a)});
        n = 0;
        while (cmd_done !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        if (cmd_done !== 1'b1) begin
            failures++;
            $display("ERROR at %0t: expected %h got %h", $time, 1'b1, cmd_done);
        end
        if (w) wr_model(a, d);
        @(posedge mclk);
        #1;
    endtask
    task automatic wrap_up;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    always @(negedge mclk) begin
        if (cmd_done === 1'b1) chk(pq.pop_front(), cmd_rdata);
        if (cmd_done === 1'b1) chk({1'b1, 32'h0000_0000}, {31'h0000_0000, cmd_busy});
        if (link_ack === 1'b1) chk(lq.pop_front(), link_rdata);
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        for (i = 0; i < NUM_REGS; i++) mem[i] = REG_RST[i];
        repeat (3) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        for (i = 0; i < NUM_REGS; i++) port_op(1'b1, 1'b0, ADDR_W'(i * 4), DATA_ZERO, 0);
        // Random mix: both strobes, unmapped places, link traffic in the wait
        for (i = 0; i < 200; i++) begin
            k = $random(seed);
            port_op(k[0], k[1] | ~k[0], k[24] ? k[16:2] : (k[16:2] & 15'h003f), $random(seed),
                int'(k[27:26]));
        end
        wrap_up();
    end
endmodule
`default_nettype wire

// ==== src/cfg_port_app.sv ====
// Application end: issues one local read or write at a time and waits for the acknowledge
`default_nettype none
module cfg_port_app (
    // Clock and reset
    input  wire logic                              mclk,
    input  wire logic                              rst_n,
    // User command side
    input  wire logic                              cmd_rd,
    input  wire logic                              cmd_wr,
    input  wire logic [cfg_port_pkg::ADDR_W-1:0]   cmd_addr,
    input  wire logic [cfg_port_pkg::DATA_W-1:0]   cmd_wdata,
    output var  logic                              cmd_busy,
    output var  logic                              cmd_done,
    output var  logic [cfg_port_pkg::DATA_W-1:0]   cmd_rdata,
    // Local port
    cfg_port_if.app                                port
);
    import cfg_port_pkg::*;

    typedef struct packed {
        app_fsm_t              st;
        logic                  rd_en;
        logic                  wr_en;
        logic                  is_wr;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     wdata;
        logic [DATA_W-1:0]     rdata;
        logic                  done;
        logic                  busy;
    } app_state_t;

    app_state_t state_r;
    app_state_t state_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        state_nxt = state_r;
        state_nxt.rd_en = 1'b0;
        state_nxt.wr_en = 1'b0;
        state_nxt.done  = 1'b0;
        case (state_r.st)
            APP_IDLE: begin
                // Write taken over read so both enables never rise together
                if (cmd_wr || cmd_rd) begin
                    state_nxt.wr_en = cmd_wr;
                    state_nxt.rd_en = !cmd_wr;
                    state_nxt.is_wr = cmd_wr;
                    state_nxt.addr  = {cmd_addr[ADDR_W-1:IDX_LSB], 2'h0};
                    state_nxt.wdata = cmd_wdata;
                    state_nxt.st    = APP_WAIT;
                end
            end
            APP_WAIT: begin
                // Nothing new is issued until the acknowledge
                if (port.ack) begin
                    state_nxt.done = 1'b1;
                    state_nxt.st   = APP_IDLE;
                    if (!state_r.is_wr) begin
                        state_nxt.rdata = port.rdata;
                    end
                end
            end
            default: begin
                state_nxt.st = APP_IDLE;
            end
        endcase
        state_nxt.busy = (state_nxt.st == APP_WAIT);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r.st    <= APP_IDLE;
            state_r.rd_en <= 1'b0;
            state_r.wr_en <= 1'b0;
            state_r.is_wr <= 1'b0;
            state_r.addr  <= '0;
            state_r.wdata <= DATA_ZERO;
            state_r.rdata <= DATA_ZERO;
            state_r.done  <= 1'b0;
            state_r.busy  <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register

    assign port.rd_en  = state_r.rd_en;
    assign port.wr_en  = state_r.wr_en;
    assign port.addr   = state_r.addr;
    assign port.wdata  = state_r.wdata;
    assign cmd_busy    = state_r.busy;
    assign cmd_done    = state_r.done;
    assign cmd_rdata   = state_r.rdata;
endmodule
`default_nettype wire

// ==== src/cfg_port_dev.sv ====
// Device end: configuration register model with link priority over the local port
`default_nettype none

// Function
// - One fabric clock, up to 250 MHz
// - Byte address selects register, low two bits ignored
// - Separate 32-bit write and read data buses
// - Port access has same effect as link access
// - Port write waits until no link access pending
// - Port read waits until no link access pending
// - Acknowledge once deferred write is carried out
// - One ack bit: write done or read valid
// - Only read and write, separate enable strobes
// - Reads allowed anytime, return any register
// - Port write changes writable bits only
// - Application writes only for header logs, debug
// - Root port: no port access during link config
module cfg_port_dev (
    // Clock and reset
    input  wire logic                              mclk,
    input  wire logic                              rst_n,
    // Local port
    cfg_port_if.dev                                port,
    // Link-side configuration requests
    input  wire logic                              link_req,
    input  wire logic                              link_we,
    input  wire logic [cfg_port_pkg::ADDR_W-1:0]   link_addr,
    input  wire logic [cfg_port_pkg::DATA_W-1:0]   link_wdata,
    output var  logic [cfg_port_pkg::DATA_W-1:0]   link_rdata,
    output var  logic                              link_ack
);
    import cfg_port_pkg::*;

    typedef struct packed {
        // Local operation taken and waiting for its turn
        dev_fsm_t                          st;
        logic                              is_wr;
        logic                              mapped;
        logic [IDX_W-1:0]                  idx;
        logic [DATA_W-1:0]                 wdata;
        // Local answer
        logic [DATA_W-1:0]                 dout;
        logic                              ack;
        // Link answer
        logic [DATA_W-1:0]                 link_dout;
        logic                              link_ack;
        // Modelled configuration registers
        logic [NUM_REGS-1:0][DATA_W-1:0]   regs;
    } dev_state_t;

    dev_state_t state_r;
    dev_state_t state_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and masked update shared by both requesters

    // Places above the modelled block are unmapped
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = ((a & UNMAPPED_MASK) == 15'h0000);
    endfunction

    // The two low address bits never reach the index
    function automatic logic [IDX_W-1:0] addr_index(input logic [ADDR_W-1:0] a);
        addr_index = a[IDX_LSB+IDX_W-1:IDX_LSB];
    endfunction

    function automatic logic [DATA_W-1:0] merge_write(input logic [DATA_W-1:0] old_v,
                                                      input logic [DATA_W-1:0] new_v,
                                                      input logic [IDX_W-1:0]  idx);
        logic [DATA_W-1:0] m;
        m = REG_WMASK[idx];
        merge_write = (old_v & ~m) | (new_v & m);
    endfunction

    // Unmapped places read as zero so the requester still gets a defined word
    function automatic logic [DATA_W-1:0] read_reg(input logic [NUM_REGS-1:0][DATA_W-1:0] regs,
                                                   input logic                             mapped,
                                                   input logic [IDX_W-1:0]                 idx);
        if (mapped) begin
            read_reg = regs[idx];
        end else begin
            read_reg = DATA_ZERO;
        end
    endfunction

    // Register file after one write; a write to an unmapped place is dropped
    function automatic logic [NUM_REGS-1:0][DATA_W-1:0] write_reg(
        input logic [NUM_REGS-1:0][DATA_W-1:0] regs,
        input logic                             mapped,
        input logic [IDX_W-1:0]                 idx,
        input logic [DATA_W-1:0]                data
    );
        logic [NUM_REGS-1:0][DATA_W-1:0] r;
        r = regs;
        if (mapped) begin
            r[idx] = merge_write(regs[idx], data, idx);
        end
        write_reg = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Request decode

    logic             link_wr_go;
    logic             link_rd_go;
    logic             link_hit;
    logic [IDX_W-1:0] link_idx;
    logic             port_go;
    logic             port_hit;
    logic [IDX_W-1:0] port_idx;
    logic             exec_now;

    // Link side
    assign link_wr_go = link_req && link_we;
    assign link_rd_go = link_req && !link_we;
    assign link_hit   = addr_mapped(link_addr);
    assign link_idx   = addr_index(link_addr);
    // Local port
    assign port_go    = port.wr_en || port.rd_en;
    assign port_hit   = addr_mapped(port.addr);
    assign port_idx   = addr_index(port.addr);
    // A taken local operation runs only in a cycle free of link requests
    assign exec_now   = (state_r.st == DEV_WAIT) && !link_req;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    // The link side always wins: its access is served in the cycle it is
    // requested, while a taken local operation sits in the wait state. A local
    // write therefore never lands in the same cycle as a link write. A link
    // write that arrives while a local write waits lands first, and the local
    // write then overwrites the writable bits.
    always_comb begin
        state_nxt          = state_r;
        state_nxt.ack      = 1'b0;
        state_nxt.link_ack = link_req;

        // Link requests are served the cycle they appear
        if (link_wr_go) begin
            state_nxt.regs = write_reg(state_r.regs, link_hit, link_idx, link_wdata);
        end
        if (link_rd_go) begin
            state_nxt.link_dout = read_reg(state_r.regs, link_hit, link_idx);
        end

        case (state_r.st)
            DEV_IDLE: begin
                // Write enable wins if both strobes arrive together
                if (port_go) begin
                    // Address and data are held so the application may move on
                    state_nxt.is_wr  = port.wr_en;
                    state_nxt.mapped = port_hit;
                    state_nxt.idx    = port_idx;
                    state_nxt.wdata  = port.wdata;
                    state_nxt.st     = DEV_WAIT;
                end
            end
            DEV_WAIT: begin
                // Held while any link access is pending
                if (exec_now) begin
                    state_nxt.ack = 1'b1;
                    state_nxt.st  = DEV_IDLE;
                    if (state_r.is_wr) begin
                        state_nxt.regs = write_reg(state_r.regs, state_r.mapped,
                                                   state_r.idx, state_r.wdata);
                    end else begin
                        state_nxt.dout = read_reg(state_r.regs, state_r.mapped, state_r.idx);
                    end
                end
            end
            default: begin
                // Unreachable with a one-bit state; recovers to idle
                state_nxt.st = DEV_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r.st        <= DEV_IDLE;
            state_r.is_wr     <= 1'b0;
            state_r.mapped    <= 1'b0;
            state_r.idx       <= '0;
            state_r.wdata     <= DATA_ZERO;
            state_r.dout      <= DATA_ZERO;
            state_r.ack       <= 1'b0;
            state_r.link_dout <= DATA_ZERO;
            state_r.link_ack  <= 1'b0;
            // Register contents return to their starting values
            state_r.regs      <= REG_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register

    // Acknowledge is a one-cycle pulse; read data holds until the next local read ends
    assign port.rdata = state_r.dout;
    assign port.ack   = state_r.ack;
    // Link answers follow each link request by one cycle
    assign link_rdata = state_r.link_dout;
    assign link_ack   = state_r.link_ack;
endmodule
`default_nettype wire
